// ==== strap_gpio_defs.svh ====
/*
  Offsets, field positions, select codes and reset values for the strap
  configuration and general-purpose pin block. Assumes word-aligned AHB-Lite
  access; included by bare name.
*/
`ifndef STRAP_GPIO_DEFS_SVH
`define STRAP_GPIO_DEFS_SVH

`define OFS_CFG 6'h00
`define OFS_STRAP 6'h01
`define OFS_PIN_CFG_A 6'h02
`define OFS_PIN_CFG_B 6'h03
`define OFS_PIN_STATE 6'h04
`define OFS_SQUELCH 6'h05

`define CFG_W 10
`define CFG_RST 10'h000
`define CFG_RATE_LSB 0
`define CFG_DDR 2
`define CFG_SERIAL 3
`define CFG_ROLE 4
`define CFG_TXCLK 5
`define CFG_AN 6
`define CFG_RECOV_FREQ 7
`define CFG_SQL_EN 8
`define CFG_DIFF 9

`define RATE_GIG 2'h2
`define REF_25MHZ 2'h2
`define PHY_ADDR_3PIN 5'h04
`define PHY_ADDR_TEST 5'h1F
`define DIFF_EN_15PIN 1'b1
`define MGMT_EN_15PIN 1'b1

`define SEL_HIZ 3'h0
`define SEL_LOW 3'h1
`define SEL_HIGH 3'h2
`define SEL_ALT3 3'h3
`define SEL_PLL 3'h4
`define SEL_RECOV 3'h5
`define SEL_ALT6 3'h6
`define SEL_ALT7 3'h7

`define PIN_CFG_A_RST 15'h0000
`define PIN_CFG_B_RST 16'h0000
`define EDGE_LO_LSB 12
`define EDGE_HI_LSB 14

`define SRC_IRQ_N 0
`define SRC_PLL 1
`define SRC_RECOV 2
`define SRC_RECOV_SQ 3
`define SRC_LINK 4
`define SRC_CRS 5
`define SRC_TE_CLK 6
`define SRC_EVT_ONE 7
`define SRC_EVT_TWO 8

`endif

// ==== strap_gpio_pkg.sv ====
/*
  Types shared by the strap configuration and general-purpose pin block.
  Assumes nothing of its surroundings.
*/
package strap_gpio_pkg;
  typedef logic [2:0] pin_sel_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} edge_mode_t;
  typedef enum logic [1:0] {GRP_IRQ_PP, GRP_IRQ_OD, GRP_B, GRP_C} pin_group_t;
endpackage

// ==== strap_config_and_gpio_mux.sv ====
/*
  Strap capture at reset release, configuration register, and the function
  multiplexer for two output pins and seven two-way pins, behind an
  AHB-Lite slave. Assumes the function sources arrive on hclk; strap and pin
  inputs come from pins and are resynchronised.
*/
`include "strap_gpio_defs.svh"

// Operation
// - strap levels sampled at reset become configuration field reset values
// - all strap pins undriven inputs during reset; drive only when configured
// - collision strap low selects 15-pin mode, high selects 3-pin mode
// - 15-pin: speed, phy address, autoneg, tx clock enable come from straps
// - 15-pin: reference clock rate code from rxd[3:2]
// - 3-pin: gigabit parallel, carrier strap picks GMII or RGMII
// - 3-pin: 25MHz reference, management enabled, phy address 0x04
// - 3-pin: SPI and autoneg on, tx clock out on, diff clock pair off
// - 3-pin: both pin select registers reset to zero
// - 3-pin: second output strap picks SGMII (low) or 1000BASE-X (high)
// - phy address straps all high enter factory test mode
// - two output pins, seven two-way pins, each low, high or undriven
// - 3-bit select per pin: 000 undriven, 001 low, 010 high
// - live two-way pin level readable while pin undriven
// - per-pin latched edge status, edge select for pins 1-3 and 4-7
// - two-way pins 4-7 usable only when parallel mode is not GMII
// - code 011 on first group: active-low interrupt, open drain on two-way
// - code 100 on every pin outputs the 125MHz PLL clock
// - code 101 on first group: recovered clock, never squelched
// - first group: 110 link status, 111 first event generator
// - second group: 011 time engine clock, 110 carrier (two-way pins 4-7: first event), 111 second event
// - second group code 101: recovered clock forced low when squelched
// - squelch from latched loss bits, held until all latched bits clear
module strap_config_and_gpio_mux
  import strap_gpio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic strap_col,
  input wire logic strap_crs,
  input wire logic [7:0] strap_rxd,
  input wire logic strap_rx_er,
  input wire logic strap_rx_dv,
  input wire logic strap_txclk,
  input wire logic gp_out_a_i,
  output logic gp_out_a_o,
  output logic gp_out_a_oe,
  input wire logic gp_out_b_i,
  output logic gp_out_b_o,
  output logic gp_out_b_oe,
  input wire logic [6:0] gp_io_i,
  output logic [6:0] gp_io_o,
  output logic [6:0] gp_io_oe,
  input wire logic intr_req_n,
  input wire logic pll_clk_125,
  input wire logic recov_clk,
  input wire logic link_up,
  input wire logic carrier_sense,
  input wire logic time_engine_clk,
  input wire logic event_gen_one,
  input wire logic event_gen_two,
  input wire logic analog_sig_loss,
  input wire logic cdr_sig_loss,
  input wire logic cdr_lock_loss,
  output logic [1:0] par_speed_sel,
  output logic par_ddr_sel,
  output logic serial_type_sel,
  output logic mii_role_sel,
  output logic tx_clk_out_en,
  output logic autoneg_enable,
  output logic recov_clk_freq_sel,
  output logic diff_tx_clk_pair_en,
  output logic [4:0] mgmt_phy_addr,
  output logic [1:0] ref_clk_rate_code,
  output logic strap_mode,
  output logic factory_test_mode,
  output logic spi_enable,
  output logic mdio_enable
);

  localparam int SYNC_W = 22;

  // ---- pin resynchronisers; no reset so straps are already settled at release
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] sync3_ff;
  logic [SYNC_W-1:0] pin_ff;
  logic [6:0] io_prev_ff;

  assign pin_raw = {strap_col, strap_crs, strap_rxd, strap_rx_er, strap_rx_dv, strap_txclk,
                    gp_out_a_i, gp_out_b_i, gp_io_i};

  always_ff @(posedge hclk) begin
    sync1_ff <= pin_raw;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
    // a bit moves only once two stages agree
    pin_ff <= (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff ^ sync3_ff));
    io_prev_ff <= pin_ff[6:0];
  end

  logic s_col, s_crs, s_rx_er, s_rx_dv, s_txclk, s_gpo_a, s_gpo_b;
  logic [7:0] s_rxd;
  logic [6:0] s_io;
  assign {s_col, s_crs, s_rxd, s_rx_er, s_rx_dv, s_txclk, s_gpo_a, s_gpo_b, s_io} = pin_ff;

  // ---- bus slave: writes zero-wait, reads one wait state
  logic [5:0] addr_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_val;
  logic wr_en;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 6'h00;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= 1'b0;
      if (rd_pend_ff) begin
        hrdata_ff <= rd_val;
        rd_pend_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
      end else if (hreadyout_ff && hready && hsel && htrans[1]) begin
        addr_ff <= haddr[7:2];
        wr_pend_ff <= hwrite;
        rd_pend_ff <= !hwrite;
        hreadyout_ff <= hwrite;
      end
    end
  end

  assign wr_en = wr_pend_ff;
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;

  // ---- strap capture and configuration
  logic strap_done_ff;
  logic [`CFG_W-1:0] cfg_ff;
  logic [4:0] phy_addr_ff;
  logic [1:0] ref_code_ff;
  logic mode_ff, test_ff, spi_en_ff, mdio_en_ff;
  logic gmii_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_ff <= 1'b0;
      cfg_ff <= `CFG_RST;
      phy_addr_ff <= 5'h00;
      ref_code_ff <= 2'h0;
      mode_ff <= 1'b0;
      test_ff <= 1'b0;
      spi_en_ff <= 1'b0;
      mdio_en_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      // one-shot capture; afterwards the straps are never looked at again
      strap_done_ff <= 1'b1;
      mode_ff <= s_col;
      test_ff <= {s_rx_er, s_rxd[7:4]} == `PHY_ADDR_TEST;
      cfg_ff <= `CFG_RST;
      cfg_ff[`CFG_DDR] <= s_crs;
      if (s_col) begin
        cfg_ff[`CFG_RATE_LSB +: 2] <= `RATE_GIG;
        cfg_ff[`CFG_SERIAL] <= s_gpo_b;
        cfg_ff[`CFG_AN] <= 1'b1;
        cfg_ff[`CFG_TXCLK] <= 1'b1;
        cfg_ff[`CFG_DIFF] <= 1'b0;
        ref_code_ff <= `REF_25MHZ;
        phy_addr_ff <= `PHY_ADDR_3PIN;
        spi_en_ff <= 1'b1;
        mdio_en_ff <= 1'b1;
      end else begin
        cfg_ff[`CFG_RATE_LSB +: 2] <= s_rxd[1:0];
        // 10/100 MII uses the second output strap for the role, serial stays SGMII
        if (!s_crs && !s_rxd[1])
          cfg_ff[`CFG_ROLE] <= s_gpo_b;
        else
          cfg_ff[`CFG_SERIAL] <= s_gpo_b;
        cfg_ff[`CFG_AN] <= s_rx_dv;
        cfg_ff[`CFG_TXCLK] <= s_txclk;
        cfg_ff[`CFG_DIFF] <= `DIFF_EN_15PIN;
        ref_code_ff <= s_rxd[3:2];
        phy_addr_ff <= {s_rx_er, s_rxd[7:4]};
        spi_en_ff <= `MGMT_EN_15PIN;
        mdio_en_ff <= `MGMT_EN_15PIN;
      end
    end else if (wr_en && hit(addr_ff, `OFS_CFG)) begin
      cfg_ff <= hwdata[`CFG_W-1:0];
    end
  end

  assign gmii_mode = !cfg_ff[`CFG_DDR] && (cfg_ff[`CFG_RATE_LSB +: 2] == `RATE_GIG);

  // ---- pin select registers
  logic [14:0] pin_cfg_a_ff;
  logic [15:0] pin_cfg_b_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cfg_a_ff <= `PIN_CFG_A_RST;
      pin_cfg_b_ff <= `PIN_CFG_B_RST;
    end else if (!strap_done_ff) begin
      pin_cfg_a_ff <= `PIN_CFG_A_RST;
      pin_cfg_b_ff <= `PIN_CFG_B_RST;
      // 15-pin: first output strap preloads two-way pin 1 with the PLL clock
      if (!s_col)
        pin_cfg_a_ff[8] <= s_gpo_a;
    end else if (wr_en && hit(addr_ff, `OFS_PIN_CFG_A)) begin
      pin_cfg_a_ff <= hwdata[14:0];
    end else if (wr_en && hit(addr_ff, `OFS_PIN_CFG_B)) begin
      pin_cfg_b_ff <= hwdata[15:0];
    end
  end

  // ---- latched status: set wins over write-one-to-clear
  function automatic logic edge_hit(input edge_mode_t m, input logic prev, input logic cur);
    case (m)
      EDGE_RISE: return !prev && cur;
      EDGE_FALL: return prev && !cur;
      EDGE_BOTH: return prev != cur;
      default: return 1'b0;
    endcase
  endfunction

  logic [6:0] io_edge;
  logic [6:0] io_latch_ff;
  logic [3:0] loss_ff;
  logic [3:0] loss_now;
  logic squelch_active;

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (i < 3)
        io_edge[i] = edge_hit(edge_mode_t'(pin_cfg_b_ff[`EDGE_LO_LSB +: 2]), io_prev_ff[i], s_io[i]);
      else
        io_edge[i] = edge_hit(edge_mode_t'(pin_cfg_b_ff[`EDGE_HI_LSB +: 2]), io_prev_ff[i], s_io[i]);
    end
  end

  assign loss_now = {!link_up, cdr_lock_loss, cdr_sig_loss, analog_sig_loss};
  assign squelch_active = |loss_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_latch_ff <= 7'h00;
      loss_ff <= 4'h0;
    end else begin
      if (wr_en && hit(addr_ff, `OFS_PIN_STATE))
        io_latch_ff <= (io_latch_ff & ~hwdata[14:8]) | (io_edge & {7{strap_done_ff}});
      else
        io_latch_ff <= io_latch_ff | (io_edge & {7{strap_done_ff}});
      if (wr_en && hit(addr_ff, `OFS_SQUELCH))
        loss_ff <= (loss_ff & ~hwdata[3:0]) | loss_now;
      else
        loss_ff <= loss_ff | loss_now;
    end
  end

  // ---- read multiplexer
  always_comb begin
    rd_val = 32'h0000_0000;
    case (addr_ff)
      `OFS_CFG: rd_val[`CFG_W-1:0] = cfg_ff;
      `OFS_STRAP: rd_val[10:0] = {mdio_en_ff, spi_en_ff, test_ff, phy_addr_ff, ref_code_ff, mode_ff};
      `OFS_PIN_CFG_A: rd_val[14:0] = pin_cfg_a_ff;
      `OFS_PIN_CFG_B: rd_val[15:0] = pin_cfg_b_ff;
      `OFS_PIN_STATE: rd_val[14:0] = {io_latch_ff, 1'b0, s_io};
      `OFS_SQUELCH: rd_val[5:0] = {link_up, squelch_active, loss_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ---- pin function multiplexer; returns {oe, level}
  // clocks pass through a flop on hclk, so they are resampled, not forwarded cleanly
  function automatic logic [1:0] pin_drive(input pin_sel_t sel, input pin_group_t grp,
                                           input logic [8:0] src);
    logic first;
    first = (grp == GRP_IRQ_PP) || (grp == GRP_IRQ_OD);
    case (sel)
      `SEL_HIZ: return 2'b00;
      `SEL_LOW: return 2'b10;
      `SEL_HIGH: return 2'b11;
      `SEL_ALT3: begin
        if (grp == GRP_IRQ_OD) return {!src[`SRC_IRQ_N], 1'b0};
        else if (grp == GRP_IRQ_PP) return {1'b1, src[`SRC_IRQ_N]};
        else return {1'b1, src[`SRC_TE_CLK]};
      end
      `SEL_PLL: return {1'b1, src[`SRC_PLL]};
      `SEL_RECOV: begin
        if (first) return {1'b1, src[`SRC_RECOV]};
        else return {1'b1, src[`SRC_RECOV_SQ]};
      end
      `SEL_ALT6: begin
        if (first) return {1'b1, src[`SRC_LINK]};
        else if (grp == GRP_B) return {1'b1, src[`SRC_CRS]};
        else return {1'b1, src[`SRC_EVT_ONE]};
      end
      `SEL_ALT7: begin
        if (first) return {1'b1, src[`SRC_EVT_ONE]};
        else return {1'b1, src[`SRC_EVT_TWO]};
      end
      default: return 2'b00;
    endcase
  endfunction

  logic [8:0] src;
  logic recov_sq;
  assign recov_sq = recov_clk && !(cfg_ff[`CFG_SQL_EN] && squelch_active);
  assign src = {event_gen_two, event_gen_one, time_engine_clk, carrier_sense, link_up,
                recov_sq, recov_clk, pll_clk_125, intr_req_n};

  logic [1:0] drv_a, drv_b;
  logic [1:0] drv_io [7];

  always_comb begin
    drv_a = pin_drive(pin_sel_t'(pin_cfg_a_ff[2:0]), GRP_IRQ_PP, src);
    drv_b = pin_drive(pin_sel_t'(pin_cfg_a_ff[5:3]), GRP_B, src);
    drv_io[0] = pin_drive(pin_sel_t'(pin_cfg_a_ff[8:6]), GRP_IRQ_OD, src);
    drv_io[1] = pin_drive(pin_sel_t'(pin_cfg_a_ff[11:9]), GRP_B, src);
    drv_io[2] = pin_drive(pin_sel_t'(pin_cfg_a_ff[14:12]), GRP_IRQ_OD, src);
    for (int i = 3; i < 7; i++) begin
      drv_io[i] = pin_drive(pin_sel_t'(pin_cfg_b_ff[3*(i-3) +: 3]), GRP_C, src);
      if (gmii_mode)
        drv_io[i] = 2'b00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {gp_out_a_oe, gp_out_a_o, gp_out_b_oe, gp_out_b_o} <= 4'h0;
      gp_io_oe <= 7'h00;
      gp_io_o <= 7'h00;
    end else if (!strap_done_ff) begin
      {gp_out_a_oe, gp_out_a_o, gp_out_b_oe, gp_out_b_o} <= 4'h0;
      gp_io_oe <= 7'h00;
      gp_io_o <= 7'h00;
    end else begin
      {gp_out_a_oe, gp_out_a_o} <= drv_a;
      {gp_out_b_oe, gp_out_b_o} <= drv_b;
      for (int i = 0; i < 7; i++) begin
        gp_io_oe[i] <= drv_io[i][1];
        gp_io_o[i] <= drv_io[i][0];
      end
    end
  end

  assign par_speed_sel = cfg_ff[`CFG_RATE_LSB +: 2];
  assign par_ddr_sel = cfg_ff[`CFG_DDR];
  assign serial_type_sel = cfg_ff[`CFG_SERIAL];
  assign mii_role_sel = cfg_ff[`CFG_ROLE];
  assign tx_clk_out_en = cfg_ff[`CFG_TXCLK];
  assign autoneg_enable = cfg_ff[`CFG_AN];
  assign recov_clk_freq_sel = cfg_ff[`CFG_RECOV_FREQ];
  assign diff_tx_clk_pair_en = cfg_ff[`CFG_DIFF];
  assign mgmt_phy_addr = phy_addr_ff;
  assign ref_clk_rate_code = ref_code_ff;
  assign strap_mode = mode_ff;
  assign factory_test_mode = test_ff;
  assign spi_enable = spi_en_ff;
  assign mdio_enable = mdio_en_ff;

  // ---- assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence capture_s;
    $rose(strap_done_ff);
  endsequence

  strap_mode_a: assert property (capture_s |-> strap_mode == $past(s_col))
    else $error("strap mode differs from collision strap");
  pin3_speed_a: assert property (capture_s and strap_mode |->
      par_speed_sel == 2'h2 && mgmt_phy_addr == 5'h04 && ref_clk_rate_code == 2'h2)
    else $error("3-pin speed, address or reference rate wrong");
  pin3_enables_a: assert property (capture_s and strap_mode |->
      autoneg_enable && tx_clk_out_en && !diff_tx_clk_pair_en && spi_enable)
    else $error("3-pin enables wrong");
  pin3_sel_a: assert property (capture_s and strap_mode |->
      pin_cfg_a_ff == 15'h0000 && pin_cfg_b_ff == 16'h0000)
    else $error("3-pin select registers not zero");
  test_mode_a: assert property (capture_s |->
      factory_test_mode == ($past({s_rx_er, s_rxd[7:4]}) == 5'h1F))
    else $error("factory test mode mismatch");
  hiz_reset_a: assert property (!strap_done_ff || $past(!strap_done_ff) |->
      gp_io_oe == 7'h00 && !gp_out_a_oe && !gp_out_b_oe)
    else $error("pin driven before strap capture");
  drive_low_a: assert property (strap_done_ff && pin_cfg_a_ff[2:0] == 3'h1 |=>
      gp_out_a_oe && !gp_out_a_o)
    else $error("output pin a not driven low");
  gmii_block_a: assert property (strap_done_ff && gmii_mode |=> gp_io_oe[6:3] == 4'h0)
    else $error("shared pins driven in GMII mode");
  irq_od_a: assert property (strap_done_ff && pin_cfg_a_ff[8:6] == 3'h3 |=>
      !gp_io_o[0] && gp_io_oe[0] == !$past(intr_req_n))
    else $error("open-drain interrupt wrong");
  squelch_a: assert property (strap_done_ff && pin_cfg_a_ff[5:3] == 3'h5 && cfg_ff[8]
      && squelch_active |=> gp_out_b_oe && !gp_out_b_o)
    else $error("recovered clock not squelched");
  squelch_hold_a: assert property (loss_ff != 4'h0 && !wr_en |=> squelch_active)
    else $error("squelch released without clear");
  edge_latch_a: assert property (strap_done_ff && io_edge[0] |=> io_latch_ff[0])
    else $error("edge not latched");

endmodule // strap_config_and_gpio_mux

// ==== board_pins.sv ====
/*
  board model: strap resistors, pull-ups and external drivers on the gp pins.
  assumes the bench sets strap levels and external drive by nba on hclk.
*/
module board_pins (
  input wire logic [14:0] strap_word,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  input wire logic gp_out_a_o,
  input wire logic gp_out_a_oe,
  input wire logic gp_out_b_o,
  input wire logic gp_out_b_oe,
  input wire logic [6:0] gp_io_o,
  input wire logic [6:0] gp_io_oe,
  output logic strap_col,
  output logic strap_crs,
  output logic [7:0] strap_rxd,
  output logic strap_rx_er,
  output logic strap_rx_dv,
  output logic strap_txclk,
  output logic gp_out_a_i,
  output logic gp_out_b_i,
  output logic [6:0] gp_io_i
);
  timeunit 1ns;
  timeprecision 100ps;
  assign {strap_col, strap_crs, strap_rxd, strap_rx_er, strap_rx_dv, strap_txclk} = strap_word[14:2];
  // an undriven output pin falls back to its strap resistor
  assign gp_out_a_i = gp_out_a_oe ? gp_out_a_o : strap_word[1];
  assign gp_out_b_i = gp_out_b_oe ? gp_out_b_o : strap_word[0];
  // pull-ups keep open-drain lines high when nobody pulls low
  assign gp_io_i = (gp_io_oe & gp_io_o) | (~gp_io_oe & ext_en & ext_val) | (~gp_io_oe & ~ext_en);
endmodule // board_pins

// ==== test_strap_config_and_gpio_mux.sv ====
/*
  self-checking bench for the strap and gp pin block: strap resets, pin
  functions, pin inputs and squelch. assumes the AHB-Lite timing of the notes.
*/
`include "strap_gpio_defs.svh"
module test_strap_config_and_gpio_mux;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'hD6326318;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, loss = 3'h0, c;
  logic hreadyout, hresp, strap_col, strap_crs, strap_rx_er, strap_rx_dv, strap_txclk;
  logic [7:0] strap_rxd, src = 8'hFF;
  logic gp_out_a_i, gp_out_a_o, gp_out_a_oe, gp_out_b_i, gp_out_b_o, gp_out_b_oe;
  logic [6:0] gp_io_i, gp_io_o, gp_io_oe, ext_en = 7'h0, ext_val = 7'h0, p7;
  logic [1:0] par_speed_sel, ref_clk_rate_code;
  logic par_ddr_sel, serial_type_sel, mii_role_sel, tx_clk_out_en, autoneg_enable;
  logic recov_clk_freq_sel, diff_tx_clk_pair_en, strap_mode, factory_test_mode;
  logic spi_enable, mdio_enable;
  logic [4:0] mgmt_phy_addr;
  logic [14:0] strap_word = 15'h0, s;
  logic [31:0] exp_q[$], mask_q[$];
  int miscompares = 0, check_count = 0;

  strap_config_and_gpio_mux strap_config_and_gpio_mux_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .strap_col(strap_col), .strap_crs(strap_crs), .strap_rxd(strap_rxd),
    .strap_rx_er(strap_rx_er), .strap_rx_dv(strap_rx_dv), .strap_txclk(strap_txclk),
    .gp_out_a_i(gp_out_a_i), .gp_out_a_o(gp_out_a_o), .gp_out_a_oe(gp_out_a_oe),
    .gp_out_b_i(gp_out_b_i), .gp_out_b_o(gp_out_b_o), .gp_out_b_oe(gp_out_b_oe),
    .gp_io_i(gp_io_i), .gp_io_o(gp_io_o), .gp_io_oe(gp_io_oe), .intr_req_n(src[7]),
    .pll_clk_125(src[6]), .recov_clk(src[5]), .link_up(src[4]), .carrier_sense(src[3]),
    .time_engine_clk(src[2]), .event_gen_one(src[1]), .event_gen_two(src[0]),
    .analog_sig_loss(loss[0]), .cdr_sig_loss(loss[1]), .cdr_lock_loss(loss[2]),
    .par_speed_sel(par_speed_sel), .par_ddr_sel(par_ddr_sel), .serial_type_sel(serial_type_sel),
    .mii_role_sel(mii_role_sel), .tx_clk_out_en(tx_clk_out_en), .autoneg_enable(autoneg_enable),
    .recov_clk_freq_sel(recov_clk_freq_sel), .diff_tx_clk_pair_en(diff_tx_clk_pair_en),
    .mgmt_phy_addr(mgmt_phy_addr), .ref_clk_rate_code(ref_clk_rate_code),
    .strap_mode(strap_mode), .factory_test_mode(factory_test_mode), .spi_enable(spi_enable),
    .mdio_enable(mdio_enable));

  board_pins board_pins_inst (.strap_word(strap_word), .ext_en(ext_en), .ext_val(ext_val),
    .gp_out_a_o(gp_out_a_o), .gp_out_a_oe(gp_out_a_oe), .gp_out_b_o(gp_out_b_o),
    .gp_out_b_oe(gp_out_b_oe), .gp_io_o(gp_io_o), .gp_io_oe(gp_io_oe), .strap_col(strap_col),
    .strap_crs(strap_crs), .strap_rxd(strap_rxd), .strap_rx_er(strap_rx_er),
    .strap_rx_dv(strap_rx_dv), .strap_txclk(strap_txclk), .gp_out_a_i(gp_out_a_i),
    .gp_out_b_i(gp_out_b_i), .gp_io_i(gp_io_i));

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  function automatic logic [31:0] next(input logic [31:0] x);
    for (int i = 0; i < 32; i++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction

  // g: 0 push-pull first group, 1 open-drain first group, 2 second group
  function automatic logic [1:0] pexp(input int g, input logic [2:0] k);
    case (k)
      3'h0: return 2'b00;
      3'h1: return 2'b10;
      3'h2: return 2'b11;
      3'h3: return (g == 1) ? {~src[7], 1'b0} : {1'b1, (g == 2) ? src[2] : src[7]};
      3'h4: return {1'b1, src[6]};
      3'h5: return {1'b1, src[5]};
      3'h6: return {1'b1, (g == 2) ? src[3] : src[4]};
      default: return {1'b1, (g == 2) ? src[0] : src[1]};
    endcase
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t output %h expected %h", $time, act, exp);
    end
  endtask

  task automatic check_rd(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t read %h expected %h", $time, act, exp);
    end
  endtask

  // read results are judged here, when the data phase completes
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      rd_phase <= 1'b0;
      if (exp_q.size() > 0) check_rd((hrdata & mask_q.pop_front()) | {hresp, 31'h0},
        exp_q.pop_front());
    end
    if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) rd_phase <= 1'b1;
  end

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 40) begin
        miscompares++;
        $display("[FAIL] %0t bus wait ran out", $time);
        end_sim;
      end
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'h0};
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    mask_q.push_back(m);
    ahb(1'b0, idx, 32'h0);
  endtask

  task automatic do_reset(input logic [14:0] st);
    hresetn <= 1'b0;
    strap_word <= st;
    repeat (20) @(posedge hclk);
    check_val({gp_out_a_oe, gp_out_b_oe, gp_io_oe}, 32'h0);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask

  task automatic cfg_check(input logic [14:0] st);
    logic [4:0] ad;
    logic [19:0] act;
    logic m;
    ad = {st[4], st[12:9]};
    // 10/100 MII: second output strap picks the role, serial type stays SGMII
    m = !st[14] && !st[13] && !st[6];
    act = {par_speed_sel, par_ddr_sel, serial_type_sel, mii_role_sel, tx_clk_out_en,
      autoneg_enable, recov_clk_freq_sel, diff_tx_clk_pair_en, mgmt_phy_addr,
      ref_clk_rate_code, strap_mode, factory_test_mode, spi_enable, mdio_enable};
    if (st[14]) check_val(act, {`RATE_GIG, st[13], st[0], 1'b0, 4'b1100, `PHY_ADDR_3PIN,
      `REF_25MHZ, 1'b1, &ad, 2'b11});
    else check_val(act, {st[6:5], st[13], st[0] & !m, st[0] & m, st[2], st[3], 2'b01, ad,
      st[8:7], 1'b0, &ad, 2'b11});
  endtask

  initial begin
    seed = next(seed);
    s = {2'b00, seed[7:2], 1'b0, seed[0], seed[8], seed[9], seed[10], 1'b1, seed[11]};
    do_reset(s);
    cfg_check(s);
    rd(`OFS_PIN_CFG_A, 32'h1C0, 32'h100);
    strap_word <= ~s;
    repeat (8) @(posedge hclk);
    cfg_check(s);
    // gmii with all address straps high
    s = {2'b00, 4'hF, seed[14:13], 2'b10, 1'b1, seed[15], seed[16], 1'b0, seed[17]};
    do_reset(s);
    cfg_check(s);
    ahb(1'b1, `OFS_PIN_CFG_B, 32'h492);
    repeat (4) @(posedge hclk);
    check_val(gp_io_oe[6:3], 32'h0);
    s = {2'b11, 1'b0, seed[20:14], 1'b0, seed[21], seed[22], seed[23], 1'b1};
    do_reset(s);
    cfg_check(s);
    rd(`OFS_PIN_CFG_A, 32'hFFFFFFFF, 32'h0);
    rd(`OFS_PIN_CFG_B, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, `OFS_PIN_CFG_B, 32'h492);
    repeat (4) @(posedge hclk);
    check_val({gp_io_oe[6:3], gp_io_o[6:3]}, 32'hFF);
    ahb(1'b1, `OFS_PIN_CFG_B, 32'h0);
    for (int p = 0; p < 16; p++) begin
      c = 3'(p);
      seed = next(seed);
      src <= seed[7:0];
      ahb(1'b1, `OFS_PIN_CFG_A, {17'h0, c, c, c, c, c});
      repeat (4) @(posedge hclk);
      check_val({gp_out_a_oe, gp_out_a_oe & gp_out_a_o, gp_out_b_oe, gp_out_b_oe & gp_out_b_o,
        gp_io_oe[0], gp_io_oe[0] & gp_io_o[0], gp_io_oe[1], gp_io_oe[1] & gp_io_o[1],
        gp_io_oe[2], gp_io_oe[2] & gp_io_o[2]},
        {pexp(0, c), pexp(2, c), pexp(1, c), pexp(2, c), pexp(1, c)});
    end
    // pin inputs: rising edges, then falling edges
    ahb(1'b1, `OFS_PIN_CFG_A, 32'h0);
    ext_en <= 7'h7F;
    ext_val <= 7'h0;
    repeat (8) @(posedge hclk);
    ahb(1'b1, `OFS_PIN_STATE, 32'h7F00);
    p7 = seed[14:8];
    ext_val <= p7;
    repeat (8) @(posedge hclk);
    rd(`OFS_PIN_STATE, 32'h7F7F, {17'h0, p7, 1'b0, p7});
    ahb(1'b1, `OFS_PIN_CFG_B, 32'h9000);
    ahb(1'b1, `OFS_PIN_STATE, 32'h7F00);
    ext_val <= 7'h0;
    repeat (8) @(posedge hclk);
    rd(`OFS_PIN_STATE, 32'h7F7F, {17'h0, p7, 8'h0});
    ext_en <= 7'h0;
    // squelch: both output pins on the recovered clock, held high
    src <= 8'hFF;
    ahb(1'b1, `OFS_CFG, 32'h16E);
    ahb(1'b1, `OFS_PIN_CFG_A, 32'h2D);
    repeat (6) @(posedge hclk);
    ahb(1'b1, `OFS_SQUELCH, 32'hF);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) src[4] <= 1'b0;
      else loss[k] <= 1'b1;
      repeat (4) @(posedge hclk);
      src <= 8'hFF;
      loss <= 3'h0;
      repeat (6) @(posedge hclk);
      check_val({gp_out_a_oe, gp_out_a_o, gp_out_b_oe, gp_out_b_o}, 32'hE);
      rd(`OFS_SQUELCH, 32'h1F, 32'h10 | (32'h1 << k));
      ahb(1'b1, `OFS_SQUELCH, 32'hF);
      repeat (6) @(posedge hclk);
      check_val({gp_out_a_oe, gp_out_a_o, gp_out_b_oe, gp_out_b_o}, 32'hF);
    end
    end_sim;
  end
endmodule // test_strap_config_and_gpio_mux
